// file: design/freq_stable_flag_pkg.sv
// package: register map, field layout and timing constants of the oscillator switch
package freq_stable_flag_pkg;
    localparam logic [7:0] OSC_CONTROL_OFFSET = 8'h8f;     // register address
    localparam int         FSEL_LSB           = 4;         // freq_select_field bits 6..4
    localparam int         FSEL_MSB           = 6;
    localparam int         STABLE_BIT         = 2;         // freq_stable_flag position
    localparam logic [2:0] FSEL_RESET         = 3'h0;      // slow source after reset
    localparam logic [2:0] FSEL_SLOW          = 3'h0;      // slow RC direct
    localparam logic [2:0] FSEL_FAST_DIRECT   = 3'h7;      // fast oscillator direct
    localparam logic [7:0] READ_MASK          = 8'h74;     // implemented bits
    localparam int         HANDOVER_EDGES     = 8;         // falling edges before handover
    localparam int         CLK_PERIOD_PS      = 4000;      // 250 MHz system clock
    localparam int         STAB_DELAY_US      = 4000;      // approx. 4 ms settle time
    localparam int         STAB_DELAY_CYCLES  = (STAB_DELAY_US * 1000) / (CLK_PERIOD_PS / 1000);
    localparam int         SLOW_HALF_PERIOD   = 64;        // 31.25 kHz model half period
    localparam int         FAST_HALF_PERIOD   = 2;         // 8 MHz model half period
endpackage : freq_stable_flag_pkg

// file: design/freq_stable_flag_src_gen.sv
// source generator: fast tap chain and slow source, as clk-domain levels
`timescale 1ns/1ps
`default_nettype none
module freq_stable_flag_src_gen
    import freq_stable_flag_pkg::*;
#(
    parameter int FAST_HALF = FAST_HALF_PERIOD,  // cycles per fast half period
    parameter int SLOW_HALF = SLOW_HALF_PERIOD   // cycles per slow half period
) (
    input  wire logic       clk,       // system clock
    input  wire logic       sys_rst,   // synchronous reset
    output logic      [7:0] src_level  // level of each selectable source, index = code
);
    logic [7:0] fast_cnt;
    logic [7:0] slow_cnt;
    logic [6:0] taps;    // taps[0] = fast direct, taps[k] = fast / 2^k
    logic       slow_lvl;

    // fast divider and postscaler chain, one counter keeps the taps phase locked
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fast_cnt <= 8'h00;
            taps     <= 7'h00;
        end else if (fast_cnt == 8'(FAST_HALF - 1)) begin
            fast_cnt <= 8'h00;
            taps     <= taps + 7'h01;
        end else begin
            fast_cnt <= fast_cnt + 8'h01;
        end
    end

    // slow RC source model
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            slow_cnt <= 8'h00;
            slow_lvl <= 1'b0;
        end else if (slow_cnt == 8'(SLOW_HALF - 1)) begin
            slow_cnt <= 8'h00;
            slow_lvl <= ~slow_lvl;
        end else begin
            slow_cnt <= slow_cnt + 8'h01;
        end
    end

    // code 111 fast direct, 110..001 halving, 000 slow direct
    assign src_level = {taps[0], taps[1], taps[2], taps[3], taps[4], taps[5], taps[6], slow_lvl};
endmodule // freq_stable_flag_src_gen
`default_nettype wire

// file: design/freq_stable_flag_edge_det.sv
// falling edge detector on a same-domain level
`timescale 1ns/1ps
`default_nettype none
module freq_stable_flag_edge_det (
    input  wire logic clk,      // system clock
    input  wire logic sys_rst,  // synchronous reset
    input  wire logic level,    // observed level
    output logic      fall      // one-cycle pulse on falling edge
);
    logic prev;

    // remember last level
    always_ff @(posedge clk) begin
        if (sys_rst) prev <= 1'b0;
        else         prev <= level;
    end

    assign fall = prev & ~level;
endmodule // freq_stable_flag_edge_det
`default_nettype wire

// file: design/freq_stable_flag_switch.sv
// internal oscillator frequency select register and glitch-free clock switcher
`timescale 1ns/1ps
`default_nettype none
// Contract
// [RULE_01] on change, park output low at old fall
// [RULE_02] count eight new-source falls, then hand over
// [RULE_03] leaving slow source clears flag, starts delay
// [RULE_04] fast-to-fast change sets flag after handover
// [RULE_05] fast-to-slow change ends without settle delay
// [RULE_06] three-bit field selects eight source frequencies
// [RULE_07] read-only stable flag at bit two
// [RULE_08] unimplemented bits 7,3,1,0 read zero
// [RULE_09] select field writable at any time
// [RULE_10] software polls flag before timing-critical work
// [RULE_11] settle delay expiry sets the stable flag
module freq_stable_flag_switch
    import freq_stable_flag_pkg::*;
#(
    parameter int STAB_CYCLES = STAB_DELAY_CYCLES,  // settle delay in clk cycles
    parameter int FAST_HALF   = FAST_HALF_PERIOD,   // fast source half period
    parameter int SLOW_HALF   = SLOW_HALF_PERIOD    // slow source half period
) (
    input  wire logic       clk,            // system clock, 250 MHz
    input  wire logic       sys_rst,        // synchronous reset, active high
    input  wire logic [7:0] reg_addr,       // register address
    input  wire logic [7:0] reg_wdata,      // write data
    input  wire logic       reg_wr,         // write strobe
    input  wire logic       reg_rd,         // read strobe
    output logic      [7:0] reg_rdata,      // read data, cycle after strobe
    output logic            clock_out_pin,  // switched clock output
    output logic            freq_stable_flag, // fast oscillator stable
    output logic            switch_busy     // switchover in progress
);
    typedef enum logic [3:0] {
        ST_RUN  = 4'b0001,  // output follows the active source
        ST_PARK = 4'b0010,  // waiting for old-source fall
        ST_HOLD = 4'b0100,  // held low, counting new-source falls
        ST_SETL = 4'b1000   // running, settle delay active
    } freq_stable_flag_state_t;

    freq_stable_flag_state_t state;
    freq_stable_flag_state_t next_state;
    logic [2:0]  freq_select;     // software select field
    logic [2:0]  active_sel;      // source currently on the output
    logic [2:0]  target_sel;      // source being switched to
    logic [3:0]  edge_cnt;
    logic [31:0] stab_cnt;
    logic [7:0]  src_level;
    logic        old_fall;
    logic        new_fall;
    logic        stable;
    logic        from_slow;

    // decoded bus accesses
    wire         hit      = (reg_addr == OSC_CONTROL_OFFSET);
    wire         wr_hit   = reg_wr & hit;
    wire         rd_hit   = reg_rd & hit;
    wire [2:0]   wr_sel   = reg_wdata[FSEL_MSB:FSEL_LSB];
    wire         change   = (freq_select != target_sel);
    wire [7:0]   rd_word  = ({1'b0, freq_select, 1'b0, stable, 2'b00}) & READ_MASK; // [RULE_08]
    wire         old_lvl  = src_level[active_sel];
    wire         new_lvl  = src_level[target_sel];
    wire         cnt_done = (edge_cnt == 4'(HANDOVER_EDGES - 1)) & new_fall;
    wire         stab_done = (stab_cnt == 32'(STAB_CYCLES - 1));

    function automatic logic is_slow(input logic [2:0] code);
        return code == FSEL_SLOW;
    endfunction

    freq_stable_flag_src_gen #(
        .FAST_HALF (FAST_HALF),
        .SLOW_HALF (SLOW_HALF)
    ) u_src (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .src_level (src_level)   // [RULE_06]
    );

    freq_stable_flag_edge_det u_old_fall (
        .clk     (clk),
        .sys_rst (sys_rst),
        .level   (old_lvl),
        .fall    (old_fall)
    );

    freq_stable_flag_edge_det u_new_fall (
        .clk     (clk),
        .sys_rst (sys_rst),
        .level   (new_lvl),
        .fall    (new_fall)
    );

    // register write; accepted in any state
    always_ff @(posedge clk) begin
        if (sys_rst)     freq_select <= FSEL_RESET;
        else if (wr_hit) freq_select <= wr_sel;   // [RULE_09]
    end

    // read data valid only in the cycle after the strobe, zero otherwise
    always_ff @(posedge clk) begin
        if (sys_rst)     reg_rdata <= 8'h00;
        else if (rd_hit) reg_rdata <= rd_word;    // [RULE_07]
        else             reg_rdata <= 8'h00;
    end

    // switch sequencer next state
    always_comb begin
        next_state = state;
        unique case (state)
            ST_RUN:  if (change) next_state = ST_PARK;
            ST_PARK: if (old_fall) next_state = ST_HOLD;                // [RULE_01]
            ST_HOLD: if (cnt_done) begin
                next_state = (from_slow && !is_slow(target_sel)) ? ST_SETL : ST_RUN; // [RULE_05]
            end
            ST_SETL: if (change) next_state = ST_PARK;
                     else if (stab_done) next_state = ST_RUN;
            default: next_state = ST_RUN;
        endcase
    end

    // sequencer, source tracking; a rewrite mid-switch is taken at the next run
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state      <= ST_RUN;
            active_sel <= FSEL_RESET;
            target_sel <= FSEL_RESET;
            from_slow  <= 1'b1;
        end else begin
            state <= next_state;
            if ((state == ST_RUN || state == ST_SETL) && change) begin
                target_sel <= freq_select;
                // a switch cut into an unfinished settle delay still counts as leaving slow
                from_slow  <= is_slow(active_sel) || (state == ST_SETL);
            end
            if (state == ST_HOLD && cnt_done) active_sel <= target_sel;  // [RULE_02]
        end
    end

    // falling edges of the new source while parked low
    always_ff @(posedge clk) begin
        if (sys_rst)                  edge_cnt <= 4'h0;
        else if (state != ST_HOLD)    edge_cnt <= 4'h0;
        else if (new_fall)            edge_cnt <= edge_cnt + 4'h1;       // [RULE_02]
    end

    // settle counter; counts only on the newly selected source's run
    always_ff @(posedge clk) begin
        if (sys_rst)                  stab_cnt <= 32'h0;
        else if (state != ST_SETL)    stab_cnt <= 32'h0;
        else if (!stab_done)          stab_cnt <= stab_cnt + 32'h1;      // [RULE_11]
    end

    // stable flag: cleared leaving slow, set on expiry or fast-to-fast handover
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stable <= 1'b0;
        end else if (state == ST_SETL && stab_done && !change) begin
            stable <= 1'b1;                                              // [RULE_11]
        end else if (state == ST_HOLD && cnt_done && !is_slow(target_sel)) begin
            stable <= !from_slow;                                        // [RULE_03] [RULE_04]
        end else if (state == ST_PARK && from_slow && !is_slow(target_sel)) begin
            stable <= 1'b0;                                              // [RULE_03]
        end
    end

    // output clock: follows the old source in park, low from its fall until handover, then follows the new source
    always_ff @(posedge clk) begin
        if (sys_rst)                            clock_out_pin <= 1'b0;
        else if (next_state == ST_HOLD || state == ST_HOLD) clock_out_pin <= 1'b0; // [RULE_01]
        else if (state == ST_PARK)              clock_out_pin <= old_lvl;
        else                                    clock_out_pin <= old_lvl;
    end

    // status outputs registered; software polls the flag before timed work
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            freq_stable_flag <= 1'b0;
            switch_busy      <= 1'b0;
        end else begin
            freq_stable_flag <= stable;                                  // [RULE_10]
            switch_busy      <= (state == ST_PARK) || (state == ST_HOLD);
        end
    end
endmodule // freq_stable_flag_switch
`default_nettype wire

// file: tb/freq_stable_flag_switch_assertions.sv
// port-level checker for the oscillator switch, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module freq_stable_flag_switch_chk (
    input wire logic       clk,              // system clock
    input wire logic       sys_rst,          // synchronous reset
    input wire logic [7:0] reg_addr,         // register address
    input wire logic [7:0] reg_wdata,        // write data
    input wire logic       reg_wr,           // write strobe
    input wire logic       reg_rd,           // read strobe
    input wire logic [7:0] reg_rdata,        // read data
    input wire logic       clock_out_pin,    // switched clock
    input wire logic       freq_stable_flag, // stable flag copy
    input wire logic       switch_busy       // switchover running
);
    logic [2:0]  tgt;     // last written select code
    logic        parked;  // output has gone low within this switchover
    logic [12:0] bcnt;    // length of the busy run since its start or the last bus write
    // shadow select; queued writes make it run ahead of the real source
    always_ff @(posedge clk) begin
        if (sys_rst) tgt <= 3'h0;
        else if (reg_wr && reg_addr == 8'h8f) tgt <= reg_wdata[6:4];
    end
    // park marker and busy length, both cleared when the switch is idle
    always_ff @(posedge clk) begin
        if (sys_rst || !switch_busy) parked <= 1'b0;
        else if ($fell(clock_out_pin)) parked <= 1'b1;
        if (sys_rst || !switch_busy || reg_wr) bcnt <= 13'h0;
        else if (bcnt != 13'h1fff) bcnt <= bcnt + 13'h1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_unmapped_zero: assert property (reg_rd && reg_addr != 8'h8f |=> reg_rdata == 8'h00)
        else $error("unmapped read returned data");
    a_reserved_zero: assert property ((reg_rdata & 8'h8b) == 8'h00)
        else $error("unimplemented bit read as one");
    a_read_select: assert property (reg_rd && reg_addr == 8'h8f |=> reg_rdata[6:4] == $past(tgt))
        else $error("select field readback wrong");
    a_park_low: assert property (parked && switch_busy |-> !clock_out_pin)
        else $error("output left low phase during switchover");
    a_write_starts: assert property (reg_wr && reg_addr == 8'h8f && !switch_busy
        && reg_wdata[6:4] != tgt |-> ##[1:3] switch_busy)
        else $error("select change did not start a switch");
    a_busy_bound: assert property (bcnt < 13'd6000)
        else $error("switchover never handed over");
    a_hand_min: assert property ($rose(switch_busy) |->
        switch_busy[*8] ##1 switch_busy[*8] ##1 switch_busy[*8])
        else $error("handover before eight new-source falls");
    a_flag_after: assert property ($rose(freq_stable_flag) |-> !switch_busy)
        else $error("stable flag set during switchover");
endmodule // freq_stable_flag_switch_chk
bind freq_stable_flag_switch freq_stable_flag_switch_chk u_chk (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .clock_out_pin, .freq_stable_flag, .switch_busy);
`default_nettype wire

// file: tb/freq_stable_flag_switch_tb.sv
// self-checking bench for the oscillator switch
`timescale 1ns/1ps
`default_nettype none
module freq_stable_flag_switch_tb;
    import freq_stable_flag_pkg::*;
    localparam int STAB = 50;  // short settle delay keeps the run brief
    logic        clk, sys_rst, reg_wr, reg_rd, clock_out_pin, freq_stable_flag, switch_busy;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, rv;
    logic [31:0] seed;
    int          n_errors, total_checks, i, k, n, p;
    freq_stable_flag_switch #(.STAB_CYCLES(STAB)) DUT (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .clock_out_pin, .freq_stable_flag, .switch_busy);
    // free-running 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic int exp_per(input logic [2:0] c);
        return (c == 3'h0) ? 2 * SLOW_HALF_PERIOD : (2 * FAST_HALF_PERIOD) << (7 - c);
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // bus cycles: one-cycle strobes, read data sampled in the following cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        rv = reg_rdata;
    endtask
    // bounded wait for the switch to go idle
    task automatic settle();
        repeat (4) @(negedge clk);
        for (n = 0; n < 6000 && switch_busy !== 1'b0; n++) @(negedge clk);
        if (n >= 6000) begin
            chk(16'h1, 16'h0, "busy timeout");
            end_of_test();
        end
    endtask
    // one full period of the output, rising edge to rising edge
    task automatic period();
        p = 0;
        for (n = 0; n < 600 && clock_out_pin !== 1'b0; n++) @(negedge clk);
        for (n = 0; n < 600 && clock_out_pin !== 1'b1; n++) @(negedge clk);
        for (n = 0; n < 600 && clock_out_pin !== 1'b0; n++) begin @(negedge clk); p++; end
        for (n = 0; n < 600 && clock_out_pin !== 1'b1; n++) begin @(negedge clk); p++; end
    endtask
    // leaving the slow source: flag low after handover, set once the delay ends
    task automatic leave_slow();
        wr(8'h8f, 8'hff);
        settle();
        chk(16'(freq_stable_flag), 16'h0, "flag not cleared");
        for (i = 0; i < STAB + 40 && freq_stable_flag !== 1'b1; i++) @(negedge clk);
        chk(16'(i >= STAB / 2 && i < STAB + 40), 16'h1, "settle delay");
        rd(8'h8f);
        chk(16'(rv), 16'h74, "fast direct readback");
        $display("test leave slow done");
    endtask
    initial begin
        {sys_rst, reg_wr, reg_rd} = 3'b100;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        n_errors = 0;
        total_checks = 0;
        seed = 32'd70905;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        rd(8'h8f);
        chk(16'(rv), 16'h0, "reset value");
        wr(8'h8e, 8'hff);
        rd(8'h8e);
        chk(16'(rv), 16'h0, "unmapped read");
        rd(8'h8f);
        chk(16'(rv), 16'h0, "unmapped write leaked");
        $display("test register access done");
        leave_slow();
        // codes 6 down to 0 in turn, fast to fast and finally fast to slow
        for (k = 6; k >= 0; k--) begin
            wr(8'h8f, {1'b0, 3'(k), 4'hf});
            settle();
            period();
            chk(16'(p), 16'(exp_per(3'(k))), "output period");
            if (k != 0) chk(16'(freq_stable_flag), 16'h1, "flag dropped");
        end
        $display("test code walk done");
        leave_slow();
        // random back-to-back writes; the second is queued behind the first
        for (k = 0; k < 6; k++) begin
            seed = lfsr(seed);
            wr(8'h8f, seed[7:0]);
            wr(8'h8f, seed[15:8]);
            settle();
            settle();
            rd(8'h8f);
            chk(16'(rv & 8'hfb), 16'(seed[15:8] & 8'h70), "queued select");
            period();
            chk(16'(p), 16'(exp_per(seed[14:12])), "random period");
        end
        $display("test random writes done");
        end_of_test();
    end
endmodule // freq_stable_flag_switch_tb
`default_nettype wire
